// File: hdl/timer_prescale_overflow_flags.sv
`timescale 1ns/100ps
`include "timer_defines.svh"

module timer_prescale_overflow_flags
(
    input  wire logic                CLK,
    input  wire logic                RST_B,
    input  wire logic                CE,
    input  wire timer_pkg::bus_req_t BUS,
    output logic [7:0]               RDATA,
    input  wire logic                TIMER_ENABLE,
    input  wire logic                FAST_FLAG_CLEAR,
    input  wire logic                AUX_CLOCK_SELECT,
    input  wire logic                LOW_FREQ_AUX_CLOCK,
    input  wire logic [15:0]         CH3_COMPARE_VALUE,
    input  wire timer_pkg::chan_evt_t CHAN_EVT,
    input  wire logic                COUNT_ACCESS,
    input  wire logic [3:0]          CHANNEL_IRQ_ENABLE,
    output logic [15:0]              FREE_RUNNING_COUNT,
    output logic [3:0]               CHANNEL_EVENT_FLAG,
    output logic                     OVERFLOW_FLAG,
    output logic                     OVERFLOW_IRQ,
    output logic                     CHANNEL_IRQ
);
    import timer_pkg::*;

    control_t                 ctl_r;
    logic     [3:0]           chan_flag_r;
    logic                     ovf_flag_r;
    logic     [7:0]           rdata_r;
    logic     [15:0]          count_r;
    logic     [15:0]          count_nxt;
    logic     [1:0]           link_div_r;
    logic                     aux_s1_r;
    logic                     aux_s2_r;
    logic                     aux_s3_r;
    logic     [`PRESC_W-1:0]  presc_r;
    logic     [2:0]           psel_act_r;
    logic                     ovf_irq_r;
    logic                     chan_irq_r;
    logic                     base_tick;
    logic                     presc_tick;
    logic                     cnt_tick;
    logic                     sel_win;
    logic                     wr_ctl;
    logic                     wr_chf;
    logic                     wr_ovf;
    logic                     rd_hit;
    logic                     wrap_to_zero;
    logic                     cmp3_reset;
    logic                     hold_zero;
    logic                     ovf_set;
    logic     [3:0]           chan_clr;
    logic                     ovf_clr;

    // low bit mask of prescale stages for a given select code
    function automatic logic [`PRESC_W-1:0] stage_mask(input logic [2:0] s);
        logic [`PRESC_W:0] one_hot;
        one_hot = {{`PRESC_W{1'b0}}, 1'b1} << s;
        stage_mask = one_hot[`PRESC_W-1:0] - {{(`PRESC_W-1){1'b0}}, 1'b1};
    endfunction

    // ---- register decode: blocking and non-blocking windows alias
    assign sel_win = (BUS.addr[15:8] == `WIN_BLOCKING)
                   || (BUS.addr[15:8] == `WIN_NONBLOCKING);
    assign wr_ctl  = CE && BUS.wr && sel_win
                   && (BUS.addr[7:0] == `OFS_CONTROL_TWO);
    assign wr_chf  = CE && BUS.wr && sel_win
                   && (BUS.addr[7:0] == `OFS_CHAN_FLAGS);
    assign wr_ovf  = CE && BUS.wr && sel_win
                   && (BUS.addr[7:0] == `OFS_OVF_FLAG);
    assign rd_hit  = CE && BUS.rd && sel_win;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctl_r <= control_t'(5'(`CONTROL_RESET));
        end
        else if (wr_ctl)
        begin
            ctl_r.ovf_irq_en    <= BUS.wdata[`CTL_OVF_IRQ_EN];
            ctl_r.cnt_reset_ch3 <= BUS.wdata[`CTL_CNT_RESET_CH3];
            ctl_r.psel <= BUS.wdata[`CTL_PSEL_HI:`CTL_PSEL_LO];
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rdata_r <= 8'h00;
        end
        else if (rd_hit)
        begin
            case (BUS.addr[7:0])
                `OFS_CONTROL_TWO:
                    rdata_r <= {ctl_r.ovf_irq_en, 3'h0,
                                ctl_r.cnt_reset_ch3, ctl_r.psel};
                `OFS_CHAN_FLAGS:
                    rdata_r <= {4'h0, chan_flag_r};
                `OFS_OVF_FLAG:
                    rdata_r <= {ovf_flag_r, 7'h00};
                default:
                    rdata_r <= 8'h00;
            endcase
        end
    end

    // ---- timer base clock as a tick on CLK
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            link_div_r <= 2'h0;
        end
        else if (CE)
        begin
            link_div_r <= link_div_r + 2'h1;
        end
    end

    // aux clock comes from another domain; two flops then edge detect
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            aux_s1_r <= 1'b0;
            aux_s2_r <= 1'b0;
            aux_s3_r <= 1'b0;
        end
        else if (CE)
        begin
            aux_s1_r <= LOW_FREQ_AUX_CLOCK;
            aux_s2_r <= aux_s1_r;
            aux_s3_r <= aux_s2_r;
        end
    end

    assign base_tick = CE && (AUX_CLOCK_SELECT
                     ? (aux_s2_r && !aux_s3_r)
                     : (link_div_r == `LINK_DIV_LAST));

    // ---- prescaler
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            presc_r <= '0;
        end
        else if (base_tick && TIMER_ENABLE)
        begin
            presc_r <= presc_r + {{(`PRESC_W-1){1'b0}}, 1'b1};
        end
    end

    // select swaps only while all prescale stages are zero
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            psel_act_r <= 3'h0;
        end
        else if (CE && presc_r == '0)
        begin
            psel_act_r <= ctl_r.psel;
        end
    end

    assign presc_tick = base_tick && TIMER_ENABLE
        && ((presc_r & stage_mask(psel_act_r))
            == stage_mask(psel_act_r));
    assign cnt_tick   = presc_tick;

    // ---- free-running counter
    assign hold_zero  = ctl_r.cnt_reset_ch3
                      && (CH3_COMPARE_VALUE == `COUNT_ZERO);
    assign cmp3_reset = ctl_r.cnt_reset_ch3
                      && (count_r == CH3_COMPARE_VALUE);
    assign wrap_to_zero = cnt_tick && (count_r == `COUNT_ALL_ONES);
    assign ovf_set    = wrap_to_zero
        && !(ctl_r.cnt_reset_ch3
             && CH3_COMPARE_VALUE == `COUNT_ALL_ONES);

    always_comb
    begin
        count_nxt = count_r;
        if (CE && hold_zero)
        begin
            count_nxt = `COUNT_ZERO;
        end
        else if (cnt_tick && cmp3_reset)
        begin
            count_nxt = `COUNT_ZERO;
        end
        else if (cnt_tick)
        begin
            count_nxt = count_r + 16'h0001;
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            count_r <= `COUNT_ZERO;
        end
        else
        begin
            count_r <= count_nxt;
        end
    end

    // ---- flags: a set in the same cycle as a clear wins
    assign chan_clr = ((wr_chf ? BUS.wdata[3:0] : 4'h0)
        | ((CE && FAST_FLAG_CLEAR)
           ? (CHAN_EVT.capture_read | CHAN_EVT.compare_write)
           : 4'h0));
    assign ovf_clr  = (wr_ovf && BUS.wdata[`OVF_FLAG_BIT])
        || (CE && FAST_FLAG_CLEAR && COUNT_ACCESS);

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            chan_flag_r <= `FLAGS_RESET;
        end
        else if (CE)
        begin
            chan_flag_r <= (chan_flag_r & ~chan_clr)
                         | CHAN_EVT.event_set;
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ovf_flag_r <= 1'b0;
        end
        else if (CE)
        begin
            ovf_flag_r <= (ovf_flag_r && !ovf_clr) || ovf_set;
        end
    end

    // ---- interrupt requests
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ovf_irq_r  <= 1'b0;
            chan_irq_r <= 1'b0;
        end
        else if (CE)
        begin
            ovf_irq_r  <= ctl_r.ovf_irq_en && ovf_flag_r;
            chan_irq_r <= |(chan_flag_r & CHANNEL_IRQ_ENABLE);
        end
    end

    assign RDATA              = rdata_r;
    assign FREE_RUNNING_COUNT = count_r;
    assign CHANNEL_EVENT_FLAG = chan_flag_r;
    assign OVERFLOW_FLAG      = ovf_flag_r;
    assign OVERFLOW_IRQ       = ovf_irq_r;
    assign CHANNEL_IRQ        = chan_irq_r;

endmodule

// File: hdl/timer_defines.svh
// Summary of operation
// - overflow interrupt request raised when enable bit set and overflow flag set
// - with counter reset enabled, a channel 3 compare match clears the counter
// - channel 3 compare value zero with reset enabled holds counter at zero
// - compare value all ones with reset enabled: no overflow flag on wrap
// - new prescale selection takes effect only when all prescale stages are zero
// - prescale select code n divides the timer base clock by two to the n
// - timer base clock is the die link clock over four or aux clock
// - each channel event flag sets on capture or compare event of its channel
// - writing one to a channel event flag clears it; zero leaves it
// - fast clear: capture read or compare write clears that channel's flag
// - overflow flag sets when the 16-bit counter wraps from all ones to zero
// - writing one to the overflow flag clears it; zero leaves it
// - fast clear: any access to the counter clears the overflow flag
// - channel interrupt enable lets that channel's flag raise an interrupt
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define ADDR_W            16
`define WIN_BLOCKING      8'h0e
`define WIN_NONBLOCKING   8'h0f
`define OFS_CONTROL_TWO   8'h2b
`define OFS_CHAN_FLAGS    8'h2c
`define OFS_OVF_FLAG      8'h2d

`define CTL_OVF_IRQ_EN    7
`define CTL_CNT_RESET_CH3 3
`define CTL_PSEL_HI       2
`define CTL_PSEL_LO       0
`define OVF_FLAG_BIT      7

`define CONTROL_RESET     8'h00
`define FLAGS_RESET       4'h0
`define COUNT_ALL_ONES    16'hffff
`define COUNT_ZERO        16'h0000
`define LINK_DIV_LAST     2'h3
`define PRESC_W           7

`endif

// File: hdl/timer_pkg.sv
package timer_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic       ovf_irq_en;
        logic       cnt_reset_ch3;
        logic [2:0] psel;
    } control_t;

    typedef struct packed {
        logic [3:0] event_set;
        logic [3:0] capture_read;
        logic [3:0] compare_write;
    } chan_evt_t;

endpackage

// File: tb/timer_checker_properties.sv
`timescale 1ns/100ps
module timer_checker
(
    input wire logic                 CLK,
    input wire logic                 RST_B,
    input wire logic                 CE,
    input wire timer_pkg::bus_req_t  BUS,
    input wire logic [7:0]           RDATA,
    input wire logic                 FAST_FLAG_CLEAR,
    input wire logic [15:0]          CH3_COMPARE_VALUE,
    input wire timer_pkg::chan_evt_t CHAN_EVT,
    input wire logic                 COUNT_ACCESS,
    input wire logic [3:0]           CHANNEL_IRQ_ENABLE,
    input wire logic [15:0]          FREE_RUNNING_COUNT,
    input wire logic [3:0]           CHANNEL_EVENT_FLAG,
    input wire logic                 OVERFLOW_FLAG,
    input wire logic                 OVERFLOW_IRQ,
    input wire logic                 CHANNEL_IRQ
);
    import timer_pkg::*;
    logic       en_r;
    logic       rst3_r;
    wire        sel = CE && BUS.addr[15:9] == 7'h07;
    wire [15:0] cnt = FREE_RUNNING_COUNT;
    wire        no_wrap = cnt != 16'hffff;
    wire [3:0]  fast = CHAN_EVT.capture_read | CHAN_EVT.compare_write;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // shadow of the two control bits
    always_ff @(posedge CLK or negedge RST_B)
        if (!RST_B)
        begin
            en_r   <= 1'b0;
            rst3_r <= 1'b0;
        end
        else if (sel && BUS.wr && BUS.addr[7:0] == 8'h2b)
        begin
            en_r   <= BUS.wdata[7];
            rst3_r <= BUS.wdata[3];
        end
    sequence chan_w1c;
        sel && BUS.wr && BUS.addr[7:0] == 8'h2c;
    endsequence
    a_ovf_irq_gate: assert property ($past(CE) |->
        OVERFLOW_IRQ == $past(OVERFLOW_FLAG & en_r)) else $error("ovf irq");
    a_chan_irq_gate: assert property ($past(CE) |-> CHANNEL_IRQ ==
        $past(|(CHANNEL_EVENT_FLAG & CHANNEL_IRQ_ENABLE)))
        else $error("ch irq");
    a_event_sets: assert property (CE |=>
        &(CHANNEL_EVENT_FLAG | ~$past(CHAN_EVT.event_set)))
        else $error("set");
    a_chan_w1c: assert property (chan_w1c |=> (CHANNEL_EVENT_FLAG &
        $past(BUS.wdata[3:0] & ~CHAN_EVT.event_set)) == 4'h0)
        else $error("w1c");
    a_fast_clr: assert property (CE && FAST_FLAG_CLEAR |=>
        (CHANNEL_EVENT_FLAG & $past(fast & ~CHAN_EVT.event_set)) == 4'h0)
        else $error("fast clear");
    a_ovf_wrap: assert property ($rose(OVERFLOW_FLAG) |->
        $past(cnt) == 16'hffff && cnt == 16'h0) else $error("ovf set");
    a_ovf_w1c: assert property (sel && BUS.wr && BUS.addr[7:0] == 8'h2d
        && BUS.wdata[7] && no_wrap |=> !OVERFLOW_FLAG) else $error("ovf w1c");
    a_cnt_clr_ovf: assert property (CE && FAST_FLAG_CLEAR && COUNT_ACCESS
        && no_wrap |=> !OVERFLOW_FLAG) else $error("count clear");
    a_zero_hold: assert property (CE && rst3_r &&
        CH3_COMPARE_VALUE == 16'h0 |=> cnt == 16'h0) else $error("hold");
    a_cmp_reset: assert property (CE && rst3_r &&
        cnt == CH3_COMPARE_VALUE |=> cnt == 16'h0 || $stable(cnt))
        else $error("cmp reset");
    a_cmp_no_ovf: assert property (CE && rst3_r &&
        CH3_COMPARE_VALUE == 16'hffff |=> !$rose(OVERFLOW_FLAG))
        else $error("ovf on cmp");
    a_cnt_step: assert property (CE |=>
        cnt - $past(cnt) <= 16'h1 || cnt == 16'h0) else $error("step");
    a_unused_zero: assert property (sel && BUS.rd &&
        BUS.addr[7:0] == 8'h2c |=> RDATA[7:4] == 4'h0) else $error("unused");
endmodule
bind timer_prescale_overflow_flags timer_checker chk
(
    .CLK                (CLK),
    .RST_B              (RST_B),
    .CE                 (CE),
    .BUS                (BUS),
    .RDATA              (RDATA),
    .FAST_FLAG_CLEAR    (FAST_FLAG_CLEAR),
    .CH3_COMPARE_VALUE  (CH3_COMPARE_VALUE),
    .CHAN_EVT           (CHAN_EVT),
    .COUNT_ACCESS       (COUNT_ACCESS),
    .CHANNEL_IRQ_ENABLE (CHANNEL_IRQ_ENABLE),
    .FREE_RUNNING_COUNT (FREE_RUNNING_COUNT),
    .CHANNEL_EVENT_FLAG (CHANNEL_EVENT_FLAG),
    .OVERFLOW_FLAG      (OVERFLOW_FLAG),
    .OVERFLOW_IRQ       (OVERFLOW_IRQ),
    .CHANNEL_IRQ        (CHANNEL_IRQ)
);

// File: tb/cpu_bus_model.sv
`timescale 1ns/100ps
module cpu_bus_model
(
    input  wire logic          clk,
    output timer_pkg::bus_req_t bus,
    input  wire logic [7:0]    rdata
);
    import timer_pkg::*;
    initial bus = '0;
    task automatic access(input logic [15:0] a, input logic [7:0] d,
                          input logic w, output logic [7:0] q);
        @(posedge clk);
        #1 bus = '{a, d, w, !w};
        @(posedge clk);
        #1 q = rdata;
        // released lines show the inverse, not the old value
        bus = '{~a, ~d, 1'b0, 1'b0};
    endtask
endmodule

// File: tb/tb_timer_prescale_overflow_flags.sv
`timescale 1ns/100ps
module tb_timer_prescale_overflow_flags;
    import timer_pkg::*;
    logic        CLK = 1'b0;
    logic        RST_B = 1'b0;
    logic        CE = 1'b1;
    bus_req_t    BUS;
    logic [7:0]  RDATA;
    logic        TIMER_ENABLE = 1'b0;
    logic        FAST_FLAG_CLEAR = 1'b0;
    logic        AUX_CLOCK_SELECT = 1'b0;
    logic        LOW_FREQ_AUX_CLOCK = 1'b0;
    logic [15:0] CH3_COMPARE_VALUE = 16'h0;
    chan_evt_t   CHAN_EVT = '0;
    logic        COUNT_ACCESS = 1'b0;
    logic [3:0]  CHANNEL_IRQ_ENABLE = 4'h0;
    logic [15:0] FREE_RUNNING_COUNT;
    logic [3:0]  CHANNEL_EVENT_FLAG;
    logic        OVERFLOW_FLAG;
    logic        OVERFLOW_IRQ;
    logic        CHANNEL_IRQ;
    int          err_count = 0;
    int          cmp_count = 0;
    logic [15:0] c0;
    logic [7:0]  q;
    always #5 CLK = ~CLK;
    always
    begin
        repeat (5) @(posedge CLK);
        #1 LOW_FREQ_AUX_CLOCK = ~LOW_FREQ_AUX_CLOCK;
    end
    timer_prescale_overflow_flags DUT
    (
        .CLK                (CLK),
        .RST_B              (RST_B),
        .CE                 (CE),
        .BUS                (BUS),
        .RDATA              (RDATA),
        .TIMER_ENABLE       (TIMER_ENABLE),
        .FAST_FLAG_CLEAR    (FAST_FLAG_CLEAR),
        .AUX_CLOCK_SELECT   (AUX_CLOCK_SELECT),
        .LOW_FREQ_AUX_CLOCK (LOW_FREQ_AUX_CLOCK),
        .CH3_COMPARE_VALUE  (CH3_COMPARE_VALUE),
        .CHAN_EVT           (CHAN_EVT),
        .COUNT_ACCESS       (COUNT_ACCESS),
        .CHANNEL_IRQ_ENABLE (CHANNEL_IRQ_ENABLE),
        .FREE_RUNNING_COUNT (FREE_RUNNING_COUNT),
        .CHANNEL_EVENT_FLAG (CHANNEL_EVENT_FLAG),
        .OVERFLOW_FLAG      (OVERFLOW_FLAG),
        .OVERFLOW_IRQ       (OVERFLOW_IRQ),
        .CHANNEL_IRQ        (CHANNEL_IRQ)
    );
    cpu_bus_model cpu (.clk(CLK), .bus(BUS), .rdata(RDATA));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpu.access(a, d, 1'b1, q);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        cpu.access(a, 8'h0, 1'b0, q);
        check({8'h0, q}, {8'h0, e});
    endtask
    task automatic evt(input chan_evt_t e);
        CHAN_EVT = e;
        tick(1);
        CHAN_EVT = '0;
    endtask
    task automatic wait_cnt(input logic [15:0] v);
        for (int i = 0; i < 400 && FREE_RUNNING_COUNT !== v; i++)
            tick(1);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        tick(12);
        RST_B = 1'b1;
        rd(16'h0e2b, 8'h00);
        rd(16'h0f2c, 8'h00);
        rd(16'h0e2d, 8'h00);
        wr(16'h0e2b, 8'hf8);
        rd(16'h0f2b, 8'h88);
        rd(16'h0e2a, 8'h00);
        rd(16'h1e2b, 8'h00);
        $display("done: registers");
        TIMER_ENABLE = 1'b1;
        tick(40);
        check(FREE_RUNNING_COUNT, 16'h0);
        CH3_COMPARE_VALUE = 16'h0010;
        wait_cnt(16'h10);
        tick(4);
        check(FREE_RUNNING_COUNT, 16'h0);
        wr(16'h0e2b, 8'h00);
        wait_cnt(16'h10);
        tick(4);
        check(FREE_RUNNING_COUNT, 16'h11);
        TIMER_ENABLE = 1'b0;
        c0 = FREE_RUNNING_COUNT;
        tick(50);
        check(FREE_RUNNING_COUNT, c0);
        TIMER_ENABLE = 1'b1;
        CE = 1'b0;
        tick(20);
        check(FREE_RUNNING_COUNT, c0);
        CE = 1'b1;
        AUX_CLOCK_SELECT = 1'b1;
        tick(40);
        c0 = FREE_RUNNING_COUNT;
        tick(200);
        check(FREE_RUNNING_COUNT - c0, 16'h14);
        check(OVERFLOW_FLAG, 1'b0);
        AUX_CLOCK_SELECT = 1'b0;
        $display("done: counter");
        for (int k = 0; k < 8; k++)
        begin
            wr(16'h0e2b, {5'h0, 3'(k)});
            tick(1024);
            c0 = FREE_RUNNING_COUNT;
            tick(64 << k);
            check(FREE_RUNNING_COUNT - c0, 16'h10);
        end
        $display("done: prescaler");
        CHANNEL_IRQ_ENABLE = 4'h2;
        evt('{4'hf, 4'h0, 4'h0});
        check(CHANNEL_EVENT_FLAG, 4'hf);
        wr(16'h0f2c, 8'hf5);
        rd(16'h0e2c, 8'h0a);
        wr(16'h0e2c, 8'h00);
        rd(16'h0e2c, 8'h0a);
        check(CHANNEL_IRQ, 1'b1);
        CHANNEL_IRQ_ENABLE = 4'h5;
        tick(2);
        check(CHANNEL_IRQ, 1'b0);
        evt('{4'h0, 4'h2, 4'h8});
        check(CHANNEL_EVENT_FLAG, 4'ha);
        FAST_FLAG_CLEAR = 1'b1;
        evt('{4'h0, 4'h2, 4'h8});
        check(CHANNEL_EVENT_FLAG, 4'h0);
        COUNT_ACCESS = 1'b1;
        tick(1);
        COUNT_ACCESS = 1'b0;
        wr(16'h0e2d, 8'h80);
        rd(16'h0e2d, 8'h00);
        CH3_COMPARE_VALUE = 16'hffff;
        wr(16'h0e2b, 8'h8f);
        tick(8);
        check(OVERFLOW_FLAG, 1'b0);
        check(OVERFLOW_IRQ, 1'b0);
        $display("done: flags");
        complete_run();
    end
    initial
    begin
        #600us;
        err_count++;
        complete_run();
    end
endmodule
